// file: hw/irqp_pkg.sv
// Behaviour
// - a source request pulse sets its pending bit to 1 and holds it.
// - with global enable set, enabled pending requests go to the core as vectors.
// - with global enable clear, no vector is requested; the core may poll.
// - bank b holds converter request in bit 3, serial peripheral in bit 2, read/write.
// - bank b bits 7..4 and 1..0 are reserved, read-only zero; software writes zeros.
// - bank c, all bits read/write, bit 7 is port A pin 7 or low-voltage detector.
// - bank c bit 6 is pin A6 or comparator 0, bit 5 pin A5 or comparator 1.
// - bank c bits 4..1 each latch port A or port D pin of the same index.
// - bank c bit 0 latches pin A0 request, source picked by a select setting.
// - bank d bit 7 latches timer A request, bit 6 the multi-channel timer.
// - bank d bits 3..0 each latch the port C pin of the same index.
// - a core acknowledge clears that source's pending bit until a new request.
// - software writing 0 to a pending bit clears it.
// - software writing 1 to a pending bit raises it as a source request would.
// - each bit has two enable bits: 00 off, 01/10/11 priority levels 1/2/3.
`default_nettype none

package irqp_pkg;

    // register word indices; byte address is four times the index
    localparam logic [11:0] IDX_BANK_B = 12'h0fc3;
    localparam logic [11:0] IDX_BANK_C = 12'h0fc6;
    localparam logic [11:0] IDX_BANK_D = 12'h0fc9;
    localparam logic [11:0] IDX_STATUS = 12'h0fd0;
    localparam logic [11:0] IDX_MASK = 12'h0fd1;
    localparam logic [11:0] IDX_CTRL = 12'h0fd2;

    localparam int ADDR_W = 14;

    // writable bits of each bank
    localparam logic [7:0] WMASK_BANK_B = 8'h0c;
    localparam logic [7:0] WMASK_BANK_C = 8'hff;
    localparam logic [7:0] WMASK_BANK_D = 8'hcf;

    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [3:0] RST_EVT = 4'h0;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // bank b field positions
    localparam int POS_CONV = 3;
    localparam int POS_SPI = 2;
    // bank c field positions
    localparam int POS_PA7_LVD = 7;
    localparam int POS_PA6_CMP0 = 6;
    localparam int POS_PA5_CMP1 = 5;
    localparam int POS_PA0 = 0;
    // bank d field positions
    localparam int POS_TMRA = 7;
    localparam int POS_MCT = 6;

    // status / mask bit positions
    localparam int EVT_BANK_B = 0;
    localparam int EVT_BANK_C = 1;
    localparam int EVT_BANK_D = 2;
    localparam int EVT_ACK = 3;
    localparam int EVT_W = 4;

    // control register: bit 0 picks the alternate source of bank c bit 0
    localparam int CTRL_PA0_SEL = 0;

    // flat request index: bank b at 23..16, bank c at 15..8, bank d at 7..0
    localparam int NSRC = 24;
    localparam int ID_W = 5;

    typedef struct packed {
        logic converter;
        logic serial_periph;
        logic [7:0] pin_a;
        logic low_voltage_detector;
        logic comparator0;
        logic comparator1;
        logic [4:1] pin_d;
        logic pin_a0_alt;
        logic timer_a;
        logic multichannel_timer;
        logic [3:0] pin_c;
    } irqp_src_t;

    typedef struct packed {
        logic [NSRC-1:0] hi;
        logic [NSRC-1:0] lo;
    } irqp_enable_t;

    typedef struct packed {
        logic req;
        logic [1:0] level;
        logic [ID_W-1:0] id;
    } irqp_vec_t;

endpackage

`default_nettype wire

// file: hw/irqp_bank.sv
`default_nettype none

module irqp_bank
    import irqp_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hff
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] set_req,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] ack_clr,
    output logic [7:0] pending_ff,
    output logic new_set
);

    logic [7:0] nxt_pending;

    // a source pulse wins over a write of 0 or an acknowledge in the same cycle
    for (genvar i = 0; i < 8; i++) begin : g_bit
        if (WMASK[i]) begin : g_rw
            assign nxt_pending[i] = set_req[i] | (wr_en ? wr_data[i] :
                                    (pending_ff[i] & ~ack_clr[i]));
        end else begin : g_rsv
            assign nxt_pending[i] = 1'b0;
        end
    end

    assign new_set = |(set_req & WMASK & ~pending_ff);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pending_ff <= RST_BANK;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

endmodule

`default_nettype wire

// file: hw/irqp_select.sv
`default_nettype none

module irqp_select
    import irqp_pkg::*;
(
    input wire logic [NSRC-1:0] pending,
    input wire irqp_enable_t enable,
    output logic found,
    output logic [1:0] level,
    output logic [ID_W-1:0] id
);

    // highest level wins; within a level the higher flat index wins
    always_comb begin
        found = 1'b0;
        level = 2'b00;
        id = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (pending[i] && ({enable.hi[i], enable.lo[i]} != 2'b00) &&
                ({enable.hi[i], enable.lo[i]} >= level)) begin
                found = 1'b1;
                level = {enable.hi[i], enable.lo[i]};
                id = ID_W'(i);
            end
        end
    end

endmodule

`default_nettype wire

// file: hw/irqp_top.sv
`default_nettype none

module irqp_top
    import irqp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire irqp_src_t src,
    input wire irqp_enable_t enable,
    input wire logic global_interrupt_enable,
    input wire logic core_ack,
    input wire logic [ID_W-1:0] core_ack_id,
    output irqp_vec_t vec,
    output logic [7:0] pending_requests_bank_b,
    output logic [7:0] pending_requests_bank_c,
    output logic [7:0] pending_requests_bank_d,
    output logic irq
);

    // bus slave: one wait cycle, answer on the second cycle of each request
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic bus_req;
    logic bus_take;
    logic bus_first;
    logic [11:0] word_idx;
    logic idx_aligned;
    logic wr_lane0;

    assign bus_req = avs_read | avs_write;
    assign bus_first = bus_req & wait_ff;
    assign bus_take = bus_req & ~wait_ff;
    assign word_idx = avs_address[ADDR_W-1:2];
    assign idx_aligned = (avs_address[1:0] == 2'b00);
    assign wr_lane0 = avs_write & bus_take & idx_aligned & avs_byteenable[0];

    logic hit_b;
    logic hit_c;
    logic hit_d;
    logic hit_status;
    logic hit_mask;
    logic hit_ctrl;

    assign hit_b = (word_idx == IDX_BANK_B);
    assign hit_c = (word_idx == IDX_BANK_C);
    assign hit_d = (word_idx == IDX_BANK_D);
    assign hit_status = (word_idx == IDX_STATUS);
    assign hit_mask = (word_idx == IDX_MASK);
    assign hit_ctrl = (word_idx == IDX_CTRL);

    logic wr_b;
    logic wr_c;
    logic wr_d;
    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;
    logic [7:0] wbyte;

    assign wbyte = avs_writedata[7:0];
    assign wr_b = wr_lane0 & hit_b;
    assign wr_c = wr_lane0 & hit_c;
    assign wr_d = wr_lane0 & hit_d;
    assign wr_status = wr_lane0 & hit_status;
    assign wr_mask = wr_lane0 & hit_mask;
    assign wr_ctrl = wr_lane0 & hit_ctrl;

    // control register
    logic [7:0] ctrl_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_ff <= RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_ff <= wbyte;
        end
    end

    // source routing into the three banks
    logic [7:0] set_b;
    logic [7:0] set_c;
    logic [7:0] set_d;
    logic pa0_src;

    assign set_b = {4'h0, src.converter, src.serial_periph, 2'b00};
    assign pa0_src = ctrl_ff[CTRL_PA0_SEL] ? src.pin_a0_alt : src.pin_a[0];
    // shared pins and peripherals of bits 7..1 are simply ored: both pulse into the same latch; bit 0 takes pa0_src
    assign set_c = {src.pin_a[7] | src.low_voltage_detector,
                    src.pin_a[6] | src.comparator0,
                    src.pin_a[5] | src.comparator1,
                    src.pin_a[4:1] | src.pin_d[4:1],
                    pa0_src};
    assign set_d = {src.timer_a, src.multichannel_timer, 2'b00, src.pin_c};

    // acknowledge decode into the flat request space
    logic [NSRC-1:0] ack_flat;

    for (genvar i = 0; i < NSRC; i++) begin : g_ack
        assign ack_flat[i] = core_ack & (core_ack_id == ID_W'(i));
    end

    logic new_b;
    logic new_c;
    logic new_d;

    irqp_bank #(
        .WMASK(WMASK_BANK_B)
    ) u_bank_b (
        .ref_clk(ref_clk),
        .srst(srst),
        .set_req(set_b),
        .wr_en(wr_b),
        .wr_data(wbyte),
        .ack_clr(ack_flat[23:16]),
        .pending_ff(pending_requests_bank_b),
        .new_set(new_b)
    );

    irqp_bank #(
        .WMASK(WMASK_BANK_C)
    ) u_bank_c (
        .ref_clk(ref_clk),
        .srst(srst),
        .set_req(set_c),
        .wr_en(wr_c),
        .wr_data(wbyte),
        .ack_clr(ack_flat[15:8]),
        .pending_ff(pending_requests_bank_c),
        .new_set(new_c)
    );

    irqp_bank #(
        .WMASK(WMASK_BANK_D)
    ) u_bank_d (
        .ref_clk(ref_clk),
        .srst(srst),
        .set_req(set_d),
        .wr_en(wr_d),
        .wr_data(wbyte),
        .ack_clr(ack_flat[7:0]),
        .pending_ff(pending_requests_bank_d),
        .new_set(new_d)
    );

    // vector selection
    logic [NSRC-1:0] pend_flat;
    logic sel_found;
    logic [1:0] sel_level;
    logic [ID_W-1:0] sel_id;

    assign pend_flat = {pending_requests_bank_b, pending_requests_bank_c,
                        pending_requests_bank_d};

    irqp_select u_select (
        .pending(pend_flat),
        .enable(enable),
        .found(sel_found),
        .level(sel_level),
        .id(sel_id)
    );

    irqp_vec_t nxt_vec;

    // an acknowledge in flight drops the request for one cycle so it is not re-sent stale
    assign nxt_vec.req = global_interrupt_enable & sel_found & ~core_ack;
    assign nxt_vec.level = sel_level;
    assign nxt_vec.id = sel_id;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vec <= '0;
        end else begin
            vec <= nxt_vec;
        end
    end

    // event status, mask and interrupt line
    logic [EVT_W-1:0] evt_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] nxt_evt;
    logic irq_ff;

    assign evt_set = {core_ack, new_d, new_c, new_b};
    // a new event wins over a write-one clear in the same cycle
    assign nxt_evt = evt_set | (evt_ff & ~(wr_status ? wbyte[EVT_W-1:0] : '0));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            evt_ff <= RST_EVT;
            mask_ff <= RST_EVT;
            irq_ff <= 1'b0;
        end else begin
            evt_ff <= nxt_evt;
            mask_ff <= wr_mask ? wbyte[EVT_W-1:0] : mask_ff;
            irq_ff <= |(nxt_evt & (wr_mask ? wbyte[EVT_W-1:0] : mask_ff));
        end
    end

    assign irq = irq_ff;

    // read data mux
    logic [7:0] rd_byte;

    assign rd_byte = !idx_aligned ? 8'h00 :
                     hit_b ? pending_requests_bank_b :
                     hit_c ? pending_requests_bank_c :
                     hit_d ? pending_requests_bank_d :
                     hit_status ? {4'h0, evt_ff} :
                     hit_mask ? {4'h0, mask_ff} :
                     hit_ctrl ? ctrl_ff : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~bus_first;
            if (bus_first && avs_read) begin
                rdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;

endmodule

`default_nettype wire

// file: testbench/irqp_monitor.sv
`default_nettype none
module irqp_monitor
    import irqp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire irqp_src_t src,
    input wire irqp_enable_t enable,
    input wire logic global_interrupt_enable,
    input wire logic core_ack,
    input wire logic [ID_W-1:0] core_ack_id,
    input wire irqp_vec_t vec,
    input wire logic [7:0] pending_requests_bank_b,
    input wire logic [7:0] pending_requests_bank_c,
    input wire logic [7:0] pending_requests_bank_d,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [NSRC-1:0] flat, rdy, set_now, set_ff, hi_ff, lo_ff;
    logic [ID_W-1:0] ack_id_ff;
    logic [7:0] wd_ff;
    assign flat = {pending_requests_bank_b, pending_requests_bank_c, pending_requests_bank_d};
    assign rdy = flat & (enable.hi | enable.lo);
    // bank c bit 0 follows a select register not visible at the ports
    assign set_now = {4'h0, src.converter, src.serial_periph, 2'h0, src.pin_a[7:1] |
        {src.low_voltage_detector, src.comparator0, src.comparator1, src.pin_d}, 1'b0,
        src.timer_a, src.multichannel_timer, 2'h0, src.pin_c};
    always_ff @(posedge ref_clk) begin
        set_ff <= srst ? '0 : set_now;
        hi_ff <= enable.hi;
        lo_ff <= enable.lo;
        ack_id_ff <= core_ack_id;
        wd_ff <= avs_writedata[7:0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence ack_seen;
        core_ack && !avs_write && src == '0;
    endsequence
    sequence bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    map_set_a: assert property (
        (flat & set_ff) == set_ff)
        else $error("pulse lost");
    rsvd_zero_a: assert property (
        (flat & ~{WMASK_BANK_B, WMASK_BANK_C, WMASK_BANK_D}) == '0)
        else $error("reserved bit set");
    vec_fwd_a: assert property (
        global_interrupt_enable && !core_ack && rdy != '0 |=> vec.req)
        else $error("no vector");
    no_vec_a: assert property (!global_interrupt_enable |=> !vec.req)
        else $error("vector while disabled");
    vec_level_a: assert property (
        vec.req |-> vec.level != 2'b00 && vec.level == {hi_ff[vec.id], lo_ff[vec.id]})
        else $error("bad level");
    ack_clr_a: assert property (ack_seen |=> !vec.req && !flat[ack_id_ff])
        else $error("ack not cleared");
    sw_write_a: assert property (
        avs_write && !avs_waitrequest && avs_byteenable[0] && !core_ack && src == '0 &&
        avs_address == {IDX_BANK_D, 2'b00}
        |=> pending_requests_bank_d == (wd_ff & WMASK_BANK_D))
        else $error("write lost");
    reset_clr_a: assert property (
        disable iff (1'b0) srst |=> flat == '0 && !vec.req && !irq)
        else $error("reset left state");
    wait_one_a: assert property (bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus timing");
endmodule
bind irqp_top irqp_monitor u_mon (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .src, .enable, .global_interrupt_enable,
    .core_ack, .core_ack_id, .vec, .pending_requests_bank_b, .pending_requests_bank_c,
    .pending_requests_bank_d, .irq);
`default_nettype wire

// file: testbench/irqp_core_model.sv
`default_nettype none
module irqp_core_model
    import irqp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire irqp_vec_t vec,
    input wire logic ack_on,
    input wire logic [3:0] ack_wait,
    output logic core_ack,
    output logic [ID_W-1:0] core_ack_id
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_ff;
    // idle id toggles so a stale id is never trusted
    always_ff @(posedge ref_clk) begin
        core_ack <= 1'b0;
        core_ack_id <= ~core_ack_id;
        cnt_ff <= 4'h0;
        if (srst) begin
            core_ack_id <= '0;
        end else if (vec.req && ack_on && !core_ack) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == ack_wait) begin
                core_ack <= 1'b1;
                core_ack_id <= vec.id;
                cnt_ff <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench
    import irqp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, core_ack, irq, gie = 1'b0, ack_on = 1'b0;
    logic [3:0] ack_wait = 4'h3;
    logic [ID_W-1:0] core_ack_id;
    logic [7:0] pb, pc, pd;
    irqp_src_t src = '0;
    irqp_src_t s[5], tmr;
    irqp_enable_t enable = '0;
    irqp_vec_t vec;
    logic [4:0] acks[$];
    logic [4:0] ae[4] = '{5'h07, 5'h13, 5'h03, 5'h06};
    logic [7:0] ce[5] = '{8'h80, 8'hc0, 8'he0, 8'hf4, 8'hf5};
    logic [11:0] wi[5] = '{IDX_BANK_B, IDX_BANK_B, IDX_BANK_D, IDX_BANK_D, IDX_BANK_C};
    logic [7:0] wd[5] = '{8'h00, 8'h0c, 8'h00, 8'hcf, 8'h00};
    logic [7:0] we[5] = '{8'h00, 8'h0c, 8'h00, 8'hcf, 8'h00};
    int num_errors = 0;
    int comparisons = 0;
    irqp_top u_dut (.ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .src, .enable,
        .global_interrupt_enable(gie), .core_ack, .core_ack_id, .vec,
        .pending_requests_bank_b(pb), .pending_requests_bank_c(pc),
        .pending_requests_bank_d(pd), .irq);
    irqp_core_model u_core (.ref_clk, .srst, .vec, .ack_on, .ack_wait, .core_ack, .core_ack_id);
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (core_ack) acks.push_back(core_ack_id);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h00_0000, d};
        // read before this edge's updates land, so this is what the slave shows at the edge
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic pulse(input irqp_src_t v);
        @(posedge ref_clk);
        src <= v;
        @(posedge ref_clk);
        src <= '0;
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge ref_clk);
        chk(irq, e);
    endtask
    task automatic conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        conclude;
    end
    initial begin
        s = '{default: '0};
        s[0].low_voltage_detector = 1'b1;
        s[1].comparator0 = 1'b1;
        s[2].comparator1 = 1'b1;
        s[3].pin_d = 4'b1010;
        s[3].pin_a = 8'h01;
        s[4].pin_a0_alt = 1'b1;
        tmr = '0;
        tmr.timer_a = 1'b1;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        enable <= '1;
        pulse('1);
        rdc(IDX_BANK_B, 8'h0c);
        rdc(IDX_BANK_C, 8'hff);
        rdc(IDX_BANK_D, 8'hcf);
        chk(vec.req, 1'b0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, wi[i], wd[i]);
            rdc(wi[i], we[i]);
        end
        rdc(12'h0fc4, 8'h00);
        bus(1'b1, IDX_CTRL, 8'h01);
        rdc(IDX_CTRL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            pulse(s[i]);
            rdc(IDX_BANK_C, ce[i]);
        end
        enable <= '{hi: 24'h08_0088, lo: 24'h00_00c0};
        gie <= 1'b1;
        ack_on <= 1'b1;
        while (acks.size() < 4) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) chk(acks[i], ae[i]);
        gie <= 1'b0;
        ack_on <= 1'b0;
        rdc(IDX_BANK_D, 8'h07);
        rdc(IDX_BANK_B, 8'h04);
        // a write without lane 0 enabled must leave the bank alone
        avs_byteenable <= 4'he;
        bus(1'b1, IDX_BANK_B, 8'h00);
        avs_byteenable <= 4'hf;
        rdc(IDX_BANK_B, 8'h04);
        bus(1'b1, IDX_STATUS, 8'h0f);
        bus(1'b1, IDX_MASK, 8'h04);
        rdc(IDX_MASK, 8'h04);
        pulse(tmr);
        irq_is(1'b1);
        rdc(IDX_STATUS, 8'h04);
        rdc(IDX_BANK_D, 8'h87);
        bus(1'b1, IDX_MASK, 8'h00);
        irq_is(1'b0);
        bus(1'b1, IDX_MASK, 8'h04);
        irq_is(1'b1);
        bus(1'b1, IDX_STATUS, 8'h04);
        irq_is(1'b0);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(IDX_BANK_B, 8'h00);
        rdc(IDX_BANK_C, 8'h00);
        rdc(IDX_BANK_D, 8'h00);
        conclude;
    end
endmodule
`default_nettype wire
